// [rtl/mercc_top.sv]
// Machine side encoder configuration, no-signal alarm and distance-coded reference check.
// Overview of operation
// - Pole select bit picks 360 or 720.
// - Polarity bit inverts machine count sign.
// - Index mark fixes position; battery keeps it.
// - Alarm 37 until setup and restart.
// - Enable bit arms no-signal alarm 21.
// - Detection width; zero means 15 um.
// - Check four marks, or three if set.
// - Mark errors retry; third raises alarm 42.
// - Distance-coded handling needs enable bit.
// - Base times 1000 over aux: exact, >=4.
// - Reference off motor position: alarm 42.
// - Zero width means base interval over four.
// - Width -1 enters setup, exposes captures.
// - Warning A3 until reference return completes.
// - Width 32767 disables reference check.
// - Battery low gives alarm 9F, live swap.
`timescale 1ns/1ns
`default_nettype none
`include "mercc_params.svh"
module mercc_top
  import mercc_pkg::*;
(
  // APB slave.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins from scale and battery, asynchronous.
  input wire mercc_pins_s pins,
  // Straps and requests from same-clock logic.
  input wire logic backup_valid,
  input wire logic ref_return_start,
  input wire logic [15:0] motor_step_um,
  input wire logic [15:0] machine_step,
  input wire mercc_motor_s motor,
  // Results.
  output logic [9:0] scale_poles,
  output logic [15:0] machine_step_out,
  output logic position_fixed,
  output logic ref_found,
  output logic alarm_event,
  output mercc_alarm_s alarms
);

  // Software parameter registers, as written.
  logic [15:0] servo_spec_word_one_ff;
  logic [15:0] servo_function_word_four_ff;
  logic [15:0] no_signal_special_width_ff;
  logic [15:0] servo_spec_word_two_ff;
  logic [15:0] base_mark_interval_ff;
  logic [15:0] auxiliary_mark_interval_ff;
  logic [15:0] check_revolution_count_ff;
  logic [15:0] check_position_high_ff;
  logic [15:0] check_position_low_ff;
  logic [15:0] check_allowed_width_ff;
  // Active copies of power-cycle parameters.
  logic [15:0] act_servo_spec_word_one_ff;
  logic [15:0] act_servo_spec_word_two_ff;
  logic [15:0] act_base_ff;
  logic [15:0] act_aux_ff;
  logic [15:0] act_width_ff;
  // Initialisation pending; forced by reset or software.
  logic init_pend_ff;
  // Pin synchronisers and filtered levels.
  logic [4:0] sync1_ff;
  logic [4:0] sync2_ff;
  logic [4:0] sync3_ff;
  logic [4:0] pin_lvl_ff;
  logic [4:0] pin_old_ff;
  // Captured values shown in setup mode.
  logic [15:0] captured_revolution_value_ff;
  logic [15:0] captured_angle_value_ff;
  logic [15:0] captured_machine_position_ff;
  // Alarm state.
  logic alarm21_ff;
  logic alarm42_ff;
  logic alarm37_ff;
  logic warn_a3_ff;
  logic fixed_ff;
  logic [15:0] lost_um_ff;
  logic [1:0] err_cnt_ff;
  logic [2:0] pass_cnt_ff;
  logic ref_found_ff;
  logic alarm_event_ff;
  logic [15:0] step_out_ff;
  mercc_state_e state_ff;
  mercc_state_e nxt_state;
  // Bus decode; the slave never waits.
  logic wr_en;
  logic rd_en;
  logic addr_hit;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign pready = 1'b1;
  // Control register strobes, one cycle long.
  logic alarm_reset;
  logic reinit;
  assign alarm_reset = wr_en & (paddr == `MERCC_OFF_CTRL) & pwdata[`MERCC_BIT_ARST];
  assign reinit = wr_en & (paddr == `MERCC_OFF_CTRL) & pwdata[`MERCC_BIT_INIT];
  // Parameter writes; stored at once, power-cycle ones used after initialisation.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      servo_spec_word_one_ff <= `MERCC_REG_RESET;
      servo_function_word_four_ff <= `MERCC_REG_RESET;
      no_signal_special_width_ff <= `MERCC_REG_RESET;
      servo_spec_word_two_ff <= `MERCC_REG_RESET;
      base_mark_interval_ff <= `MERCC_REG_RESET;
      auxiliary_mark_interval_ff <= `MERCC_REG_RESET;
      check_revolution_count_ff <= `MERCC_REG_RESET;
      check_position_high_ff <= `MERCC_REG_RESET;
      check_position_low_ff <= `MERCC_REG_RESET;
      check_allowed_width_ff <= `MERCC_REG_RESET;
    end else if (wr_en) begin
      case (paddr)
        `MERCC_OFF_SERVO_SPEC_WORD_ONE: servo_spec_word_one_ff <= pwdata[15:0];
        `MERCC_OFF_FUNC4: servo_function_word_four_ff <= pwdata[15:0];
        `MERCC_OFF_NSW: no_signal_special_width_ff <= pwdata[15:0];
        `MERCC_OFF_SERVO_SPEC_WORD_TWO: servo_spec_word_two_ff <= pwdata[15:0];
        `MERCC_OFF_BASE: base_mark_interval_ff <= pwdata[15:0];
        `MERCC_OFF_AUX: auxiliary_mark_interval_ff <= pwdata[15:0];
        `MERCC_OFF_CREV: check_revolution_count_ff <= pwdata[15:0];
        `MERCC_OFF_CPHI: check_position_high_ff <= pwdata[15:0];
        `MERCC_OFF_CPLO: check_position_low_ff <= pwdata[15:0];
        `MERCC_OFF_CWID: check_allowed_width_ff <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Power-cycle parameters are copied only while initialising, so a
  // running axis never sees its scale geometry change under it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_pend_ff <= 1'b1;
      act_servo_spec_word_one_ff <= `MERCC_REG_RESET;
      act_servo_spec_word_two_ff <= `MERCC_REG_RESET;
      act_base_ff <= `MERCC_REG_RESET;
      act_aux_ff <= `MERCC_REG_RESET;
      act_width_ff <= `MERCC_REG_RESET;
    end else begin
      init_pend_ff <= reinit;
      if (init_pend_ff) begin
        act_servo_spec_word_one_ff <= servo_spec_word_one_ff;
        act_servo_spec_word_two_ff <= servo_spec_word_two_ff;
        act_base_ff <= base_mark_interval_ff;
        act_aux_ff <= auxiliary_mark_interval_ff;
        act_width_ff <= check_allowed_width_ff;
      end
    end
  end

  // Three-stage synchroniser; a level counts once stages two and three agree.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 5'h00;
      sync2_ff <= 5'h00;
      sync3_ff <= 5'h00;
      pin_lvl_ff <= 5'h00;
      pin_old_ff <= 5'h00;
    end else begin
      sync1_ff <= pins;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      pin_lvl_ff <= (~(sync2_ff ^ sync3_ff) & sync3_ff) | ((sync2_ff ^ sync3_ff) & pin_lvl_ff);
      pin_old_ff <= pin_lvl_ff;
    end
  end

  // Filtered levels and rising edges, in struct order.
  mercc_pins_s lvl;
  mercc_pins_s rise;
  assign lvl = pin_lvl_ff;
  assign rise = pin_lvl_ff & ~pin_old_ff;
  // Scale geometry and polarity from the active copy.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_out_ff <= 16'h0000;
    end else if (act_servo_spec_word_one_ff[`MERCC_BIT_SDIR]) begin
      step_out_ff <= 16'(~machine_step + 16'h0001);
    end else begin
      step_out_ff <= machine_step;
    end
  end
  assign scale_poles = act_servo_spec_word_one_ff[`MERCC_BIT_POLE] ? `MERCC_POLES_HI : `MERCC_POLES_STD;
  assign machine_step_out = step_out_ff;
  // Absolute position within a rotation; the battery strap carries it over
  // power-off, so alarm 37 can only leave at an initialisation.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fixed_ff <= 1'b0;
      alarm37_ff <= 1'b1;
    end else begin
      fixed_ff <= fixed_ff | rise.index_mark | (init_pend_ff & backup_valid);
      if (init_pend_ff) begin
        alarm37_ff <= ~(backup_valid | fixed_ff);
      end
    end
  end
  assign position_fixed = fixed_ff;
  // No-signal travel: motion counted while the scale is silent.
  logic [15:0] nosig_width;
  logic [15:0] step_abs;
  logic [16:0] lost_sum;
  logic nosig_cause;
  assign nosig_width = (no_signal_special_width_ff == 16'h0000) ? `MERCC_NOSIG_DEF_UM
                       : {1'b0, no_signal_special_width_ff[14:0]};
  assign step_abs = motor_step_um[15] ? 16'(~motor_step_um + 16'h0001) : motor_step_um;
  assign lost_sum = {1'b0, lost_um_ff} + {1'b0, step_abs};
  assign nosig_cause = servo_function_word_four_ff[`MERCC_BIT_NOSIG] & ~lvl.signal_ok
                       & (lost_um_ff >= nosig_width);
  // Distance accumulator saturates rather than wrapping back below the width.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lost_um_ff <= 16'h0000;
    end else if (lvl.signal_ok || !servo_function_word_four_ff[`MERCC_BIT_NOSIG]) begin
      lost_um_ff <= 16'h0000;
    end else begin
      lost_um_ff <= lost_sum[16] ? 16'hffff : lost_sum[15:0];
    end
  end

  // Distance-coded connection test and check width.
  logic [31:0] base_scaled;
  logic [31:0] aux_wide;
  logic dc_connected;
  logic dc_active;
  logic setup_mode;
  logic check_on;
  logic [31:0] check_width;
  logic [31:0] pos_diff;
  logic [31:0] pos_abs;
  logic [2:0] marks_needed;
  assign base_scaled = 32'({16'h0000, act_base_ff} * `MERCC_INTERVAL_SCALE);
  assign aux_wide = {16'h0000, act_aux_ff};
  assign dc_connected = (aux_wide != 32'h0000_0000) && (base_scaled % aux_wide == 32'h0000_0000)
                        && (base_scaled >= 32'(aux_wide * `MERCC_MIN_RATIO));
  assign dc_active = act_servo_spec_word_two_ff[`MERCC_BIT_DCEN] & dc_connected;
  assign setup_mode = dc_active & (act_width_ff == `MERCC_WID_SETUP);
  assign check_on = dc_active & ~setup_mode & (act_width_ff != `MERCC_WID_OFF);
  assign check_width = (act_width_ff == 16'h0000) ? {18'h00000, act_base_ff[15:2]}
                       : {16'h0000, act_width_ff};
  assign pos_diff = 32'(motor.ref_point_pos - motor.motor_point_pos);
  assign pos_abs = pos_diff[31] ? 32'(~pos_diff + 32'h0000_0001) : pos_diff;
  assign marks_needed = act_servo_spec_word_two_ff[`MERCC_BIT_MARKS] ? `MERCC_MARKS_RED : `MERCC_MARKS_STD;
  // Search outcome terms.
  logic marks_complete;
  logic err_limit;
  logic check_fail;
  assign marks_complete = rise.mark_pass & (pass_cnt_ff + 3'h1 >= marks_needed);
  assign err_limit = rise.mark_error & (err_cnt_ff + 2'h1 == `MERCC_ERR_LIMIT);
  assign check_fail = check_on & (pos_abs > check_width);
  // Reference mark search sequence.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      MERCC_IDLE: begin
        if (ref_return_start && dc_active) begin
          nxt_state = MERCC_SEARCH;
        end
      end
      MERCC_SEARCH: begin
        // An error retries at the next mark; only the limit ends the search.
        if (err_limit) begin
          nxt_state = MERCC_FAIL;
        end else if (marks_complete) begin
          nxt_state = check_fail ? MERCC_FAIL : MERCC_DONE;
        end
      end
      MERCC_DONE, MERCC_FAIL: begin
        if (ref_return_start && dc_active) begin
          nxt_state = MERCC_SEARCH;
        end
      end
      default: nxt_state = MERCC_IDLE;
    endcase
  end

  // State, counters and found pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= MERCC_IDLE;
      pass_cnt_ff <= 3'h0;
      err_cnt_ff <= 2'h0;
      ref_found_ff <= 1'b0;
    end else begin
      state_ff <= init_pend_ff ? MERCC_IDLE : nxt_state;
      ref_found_ff <= (state_ff == MERCC_SEARCH) && (nxt_state == MERCC_DONE);
      if (state_ff != MERCC_SEARCH) begin
        pass_cnt_ff <= 3'h0;
      end else if (rise.mark_pass && !rise.mark_error) begin
        pass_cnt_ff <= pass_cnt_ff + 3'h1;
      end
      // Errors add up over retries until software resets the alarm.
      if (alarm_reset || init_pend_ff) begin
        err_cnt_ff <= 2'h0;
      end else if (state_ff == MERCC_SEARCH && rise.mark_error && err_cnt_ff != `MERCC_ERR_LIMIT) begin
        err_cnt_ff <= err_cnt_ff + 2'h1;
      end
    end
  end
  assign ref_found = ref_found_ff;
  // Captured motor values at the found reference, for setup readout.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      captured_revolution_value_ff <= 16'h0000;
      captured_angle_value_ff <= 16'h0000;
      captured_machine_position_ff <= 16'h0000;
    end else if (setup_mode && state_ff == MERCC_SEARCH && nxt_state == MERCC_DONE) begin
      captured_revolution_value_ff <= motor.motor_rev;
      captured_angle_value_ff <= motor.motor_angle;
      captured_machine_position_ff <= motor.motor_pos_lo;
    end
  end

  // Sticky alarms: a new cause wins over a reset in the same cycle, except for alarm 42 when it is already set.
  logic set21;
  logic set42;
  assign set21 = nosig_cause & ~alarm21_ff;
  assign set42 = (state_ff == MERCC_SEARCH) & (nxt_state == MERCC_FAIL) & ~alarm42_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm21_ff <= 1'b0;
      alarm42_ff <= 1'b0;
      alarm_event_ff <= 1'b0;
    end else begin
      alarm21_ff <= nosig_cause | (alarm21_ff & ~alarm_reset);
      alarm42_ff <= set42 | (alarm42_ff & ~alarm_reset);
      alarm_event_ff <= set21 | set42;
    end
  end
  assign alarm_event = alarm_event_ff;
  // Setup warning holds until a reference return completes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_a3_ff <= 1'b0;
    end else if (init_pend_ff) begin
      warn_a3_ff <= 1'b0;
    end else if (setup_mode && state_ff == MERCC_SEARCH && nxt_state == MERCC_DONE) begin
      warn_a3_ff <= 1'b0;
    end else if (setup_mode && state_ff == MERCC_IDLE) begin
      warn_a3_ff <= 1'b1;
    end
  end

  // Battery alarm follows the pin; replacement under power keeps position.
  assign alarms.alarm_21 = alarm21_ff;
  assign alarms.alarm_42 = alarm42_ff;
  assign alarms.alarm_37 = alarm37_ff;
  assign alarms.alarm_9f = lvl.battery_low;
  assign alarms.warn_a3 = warn_a3_ff;
  // Status word layout.
  logic [15:0] status_word;
  assign status_word = {4'h0, err_cnt_ff, dc_active, setup_mode, ref_found_ff, dc_connected,
                        fixed_ff, warn_a3_ff, lvl.battery_low, alarm37_ff, alarm42_ff, alarm21_ff};
  // Read mux; unmapped addresses answer with an error and zero data.
  logic [15:0] rd_word;
  always_comb begin
    rd_word = 16'h0000;
    addr_hit = 1'b1;
    case (paddr)
      `MERCC_OFF_SERVO_SPEC_WORD_ONE: rd_word = servo_spec_word_one_ff;
      `MERCC_OFF_FUNC4: rd_word = servo_function_word_four_ff;
      `MERCC_OFF_NSW: rd_word = no_signal_special_width_ff;
      `MERCC_OFF_SERVO_SPEC_WORD_TWO: rd_word = servo_spec_word_two_ff;
      `MERCC_OFF_BASE: rd_word = base_mark_interval_ff;
      `MERCC_OFF_AUX: rd_word = auxiliary_mark_interval_ff;
      `MERCC_OFF_CREV: rd_word = check_revolution_count_ff;
      `MERCC_OFF_CPHI: rd_word = check_position_high_ff;
      `MERCC_OFF_CPLO: rd_word = check_position_low_ff;
      `MERCC_OFF_CWID: rd_word = check_allowed_width_ff;
      `MERCC_OFF_CTRL: rd_word = 16'h0000;
      `MERCC_OFF_STAT: rd_word = status_word;
      // Captures read as zero outside setup mode.
      `MERCC_OFF_CAPREV: rd_word = setup_mode ? captured_revolution_value_ff : 16'h0000;
      `MERCC_OFF_CAPANG: rd_word = setup_mode ? captured_angle_value_ff : 16'h0000;
      `MERCC_OFF_CAPPOS: rd_word = setup_mode ? captured_machine_position_ff : 16'h0000;
      default: addr_hit = 1'b0;
    endcase
  end
  assign prdata = rd_en ? {16'h0000, rd_word} : 32'h0000_0000;
  assign pslverr = psel & penable & ~addr_hit;
endmodule : mercc_top
`default_nettype wire

// [common/mercc_params.svh]
// Register offsets, field positions, reset values and limits for the machine encoder check block.
`ifndef MERCC_PARAMS_SVH
`define MERCC_PARAMS_SVH
`define MERCC_OFF_SERVO_SPEC_WORD_ONE 8'h00
`define MERCC_OFF_FUNC4 8'h04
`define MERCC_OFF_NSW 8'h08
`define MERCC_OFF_SERVO_SPEC_WORD_TWO 8'h0c
`define MERCC_OFF_BASE 8'h10
`define MERCC_OFF_AUX 8'h14
`define MERCC_OFF_CREV 8'h18
`define MERCC_OFF_CPHI 8'h1c
`define MERCC_OFF_CPLO 8'h20
`define MERCC_OFF_CWID 8'h24
`define MERCC_OFF_CTRL 8'h28
`define MERCC_OFF_STAT 8'h2c
`define MERCC_OFF_CAPREV 8'h30
`define MERCC_OFF_CAPANG 8'h34
`define MERCC_OFF_CAPPOS 8'h38
`define MERCC_BIT_POLE 8
`define MERCC_BIT_SDIR 4
`define MERCC_BIT_NOSIG 7
`define MERCC_BIT_MARKS 7
`define MERCC_BIT_DCEN 3
`define MERCC_BIT_ARST 0
`define MERCC_BIT_INIT 1
`define MERCC_REG_RESET 16'h0000
`define MERCC_POLES_STD 10'h168
`define MERCC_POLES_HI 10'h2d0
`define MERCC_NOSIG_DEF_UM 16'h000f
`define MERCC_MARKS_STD 3'h4
`define MERCC_MARKS_RED 3'h3
`define MERCC_ERR_LIMIT 2'h3
`define MERCC_INTERVAL_SCALE 32'h0000_03e8
`define MERCC_MIN_RATIO 32'h0000_0004
`define MERCC_WID_SETUP 16'hffff
`define MERCC_WID_OFF 16'h7fff
`endif

// [common/mercc_pkg.sv]
// Types shared by the machine encoder check block.
package mercc_pkg;
  // Reference mark search states.
  typedef enum logic [1:0] {
    MERCC_IDLE = 2'b00,
    MERCC_SEARCH = 2'b01,
    MERCC_DONE = 2'b10,
    MERCC_FAIL = 2'b11
  } mercc_state_e;
  // Raw pins from the scale and battery circuit.
  typedef struct packed {
    logic index_mark;
    logic signal_ok;
    logic battery_low;
    logic mark_pass;
    logic mark_error;
  } mercc_pins_s;
  // Motor side absolute data and computed reference point, same clock.
  typedef struct packed {
    logic [31:0] ref_point_pos;
    logic [31:0] motor_point_pos;
    logic [15:0] motor_rev;
    logic [15:0] motor_angle;
    logic [15:0] motor_pos_lo;
  } mercc_motor_s;
  // Alarm and warning levels.
  typedef struct packed {
    logic alarm_21;
    logic alarm_42;
    logic alarm_37;
    logic alarm_9f;
    logic warn_a3;
  } mercc_alarm_s;
endpackage : mercc_pkg

// [bench/mercc_checker.sv]
// Port-level assertions for the machine encoder check block.
`timescale 1ns/1ns
`default_nettype none
`include "mercc_params.svh"
module mercc_checker
  import mercc_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Register bus.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Scale side and results.
  input wire mercc_pins_s pins,
  input wire logic [15:0] machine_step,
  input wire logic [9:0] scale_poles,
  input wire logic [15:0] machine_step_out,
  input wire logic ref_found,
  input wire logic alarm_event,
  input wire mercc_alarm_s alarms
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Software asks for an alarm reset in this access.
  logic clr_req;
  assign clr_req = psel && penable && pwrite && paddr == `MERCC_OFF_CTRL && pwdata[`MERCC_BIT_ARST];
  bus_ready_a: assert property (psel && penable |-> pready) else $error("pready low in access");
  slverr_phase_a: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
  read_idle_a: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0) else $error("prdata not zero");
  pole_legal_a: assert property (scale_poles == `MERCC_POLES_STD || scale_poles == `MERCC_POLES_HI)
    else $error("illegal pole count");
  step_sign_a: assert property (1'b1 |=> machine_step_out == $past(machine_step) ||
    machine_step_out == 16'h0 - $past(machine_step)) else $error("machine step mangled");
  found_pulse_a: assert property (ref_found |=> !ref_found) else $error("ref_found too long");
  event_pulse_a: assert property (alarm_event |=> !alarm_event) else $error("alarm_event too long");
  event_cause_a: assert property (alarm_event |-> alarms.alarm_21 || alarms.alarm_42)
    else $error("event without alarm");
  // Alarm 42 must be held until software resets it.
  a42_sticky_a: assert property ($fell(alarms.alarm_42) |-> $past(clr_req) || $past(clr_req, 2))
    else $error("alarm 42 dropped");
  battery_follow_a: assert property ($stable(pins.battery_low) [*8] |-> alarms.alarm_9f == pins.battery_low)
    else $error("alarm 9F not following");
  a3_clear_a: assert property ($fell(alarms.warn_a3) |-> ##[0:2] ref_found) else $error("A3 dropped early");
  cover property (ref_found);
  cover property (alarm_event);
  cover property (pslverr);
  cover property ($fell(alarms.warn_a3));
endmodule : mercc_checker
`default_nettype wire

// [bench/mercc_scale_model.sv]
// Behavioural machine side scale and battery pins.
`timescale 1ns/1ns
`default_nettype none
module mercc_scale_model
  import mercc_pkg::*;
(
  // Drive clock.
  input wire logic pclk,
  // Pins toward the drive.
  output var mercc_pins_s pins
);
  // Idle state: signal present, no marks, battery good.
  initial pins = 5'h08;
  // A level changes just after an edge.
  task automatic set(input int b, input logic v);
    @(posedge pclk);
    pins[b] <= v;
  endtask : set
  // Five-cycle pulses, well above the two cycles the synchroniser needs to see a level.
  task automatic pulse(input int b);
    set(b, 1'b1);
    repeat (4) @(posedge pclk);
    set(b, 1'b0);
    repeat (4) @(posedge pclk);
  endtask : pulse
endmodule : mercc_scale_model
`default_nettype wire

// [bench/mercc_tb_top.sv]
// Self-checking bench for the machine encoder check block.
`timescale 1ns/1ns
`default_nettype none
`include "mercc_params.svh"
module mercc_tb_top
  import mercc_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, backup_valid, ref_return_start;
  logic [7:0] paddr, a;
  logic [31:0] pwdata, prdata, rd, d;
  logic pready, pslverr, rerr, position_fixed, ref_found, alarm_event, fnd, bad;
  logic [15:0] motor_step_um, machine_step, machine_step_out;
  logic [9:0] scale_poles;
  mercc_pins_s pins;
  mercc_motor_s motor;
  mercc_alarm_s alarms;
  int num_errors, samples_checked, found_cnt, ev_cnt, f0, e0, w;
  // Row tables for the sweeps.
  int cb[6] = '{1, 1, 1, 2, 3, 1};
  int ca[6] = '{250, 200, 300, 500, 1000, 0};
  int nsw[3] = '{0, 0, 30};
  int dc[6] = '{1, 1, 1, 1, 1, 0};
  int sz[6] = '{0, 1, 0, 1, 0, 0};
  int cw[6] = '{0, 0, 32767, 5, 5, 0};
  int df[6] = '{2, 3, 900, 5, 2, 0};
  int ne[6] = '{0, 0, 0, 2, 3, 0};
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  mercc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .backup_valid(backup_valid), .ref_return_start(ref_return_start), .motor_step_um(motor_step_um),
    .machine_step(machine_step), .motor(motor), .scale_poles(scale_poles), .machine_step_out(machine_step_out),
    .position_fixed(position_fixed), .ref_found(ref_found), .alarm_event(alarm_event), .alarms(alarms));
  mercc_scale_model scale (.pclk(pclk), .pins(pins));
  // Count pulses so short events are never missed.
  always @(posedge pclk) begin
    if (ref_found === 1'b1) found_cnt++;
    if (alarm_event === 1'b1) ev_cnt++;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One APB transfer; data is taken at the edge that ends it.
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    apb(1'b1, ad, wd);
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    chk(nm, rd, exp);
  endtask : rdc
  // Parameters of the power-cycle kind only apply here.
  task automatic reinit;
    wr(`MERCC_OFF_CTRL, 32'h2);
    cyc(3);
  endtask : reinit
  function automatic logic conn_exp(input int b, input int x);
    return x != 0 && (b * 1000) % x == 0 && b * 1000 >= 4 * x;
  endfunction : conn_exp
  function automatic logic found_exp(input int i);
    w = (cw[i] == 0) ? 2 : cw[i];
    return dc[i] == 1 && ne[i] < 3 && (cw[i] == 32767 || df[i] <= w);
  endfunction : found_exp
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    cyc(20000);
    num_errors++;
    end_sim();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, backup_valid, ref_return_start} = '0;
    {motor_step_um, machine_step, motor} = '0;
    presetn = 1'b0;
    rd = $urandom(42839);
    cyc(5);
    presetn <= 1'b1;
    for (int i = 0; i <= 14; i++) rdc("reset", 8'(4 * i), i == 11 ? 32'h4 : 32'h0);
    rdc("unmapped", 8'h3c, 32'h0);
    chk("slverr", rerr, 32'h1);
    $display("test reset done");
    repeat (20) begin
      a = 8'(4 * ($urandom % 10));
      if (a == `MERCC_OFF_NSW) a = `MERCC_OFF_SERVO_SPEC_WORD_ONE;
      d = $urandom;
      wr(a, d);
      rdc("readback", a, {16'h0, d[15:0]});
    end
    $display("test registers done");
    for (int p = 0; p < 2; p++) begin
      wr(`MERCC_OFF_SERVO_SPEC_WORD_ONE, p ? 32'h110 : 32'h0);
      machine_step <= 16'($urandom);
      cyc(2);
      chk("poles held", scale_poles, 32'd360);
      reinit();
      chk("poles", scale_poles, p ? 32'd720 : 32'd360);
      chk("step", machine_step_out, p ? 16'(-machine_step) : machine_step);
    end
    chk("unfixed", position_fixed, 32'h0);
    scale.pulse(4);
    cyc(4);
    chk("fixed", position_fixed, 32'h1);
    backup_valid <= 1'b1;
    reinit();
    chk("alarm37", alarms.alarm_37, 32'h0);
    $display("test setup done");
    for (int i = 0; i < 3; i++) begin
      wr(`MERCC_OFF_FUNC4, i ? 32'h80 : 32'h0);
      wr(`MERCC_OFF_NSW, 32'(nsw[i]));
      motor_step_um <= 16'h1;
      e0 = ev_cnt;
      w = nsw[i] ? nsw[i] : 15;
      scale.set(3, 1'b0);
      cyc(w);
      chk("nosig early", alarms.alarm_21, 32'h0);
      cyc(10);
      chk("nosig", alarms.alarm_21, i ? 32'h1 : 32'h0);
      chk("nosig event", 32'(ev_cnt - e0), i ? 32'h1 : 32'h0);
      scale.set(3, 1'b1);
      motor_step_um <= 16'h0;
      cyc(8);
      wr(`MERCC_OFF_CTRL, 32'h1);
      cyc(2);
      chk("nosig clear", alarms.alarm_21, 32'h0);
    end
    $display("test no signal done");
    for (int i = 0; i < 6; i++) begin
      wr(`MERCC_OFF_SERVO_SPEC_WORD_TWO, 32'h8);
      wr(`MERCC_OFF_BASE, 32'(cb[i]));
      wr(`MERCC_OFF_AUX, 32'(ca[i]));
      reinit();
      apb(1'b0, `MERCC_OFF_STAT, 32'h0);
      chk("connected", rd[6], conn_exp(cb[i], ca[i]));
    end
    wr(`MERCC_OFF_BASE, 32'd8);
    wr(`MERCC_OFF_AUX, 32'd2000);
    for (int i = 0; i < 7; i++) begin
      fnd = (i < 6) ? found_exp(i) : 1'b1;
      bad = (i < 6) ? dc[i] == 1 && !fnd : 1'b0;
      wr(`MERCC_OFF_SERVO_SPEC_WORD_TWO, i < 6 ? 32'(sz[i] * 128 + dc[i] * 8) : 32'h8);
      wr(`MERCC_OFF_CWID, i < 6 ? 32'(cw[i]) : 32'hffff);
      wr(`MERCC_OFF_CTRL, 32'h1);
      reinit();
      motor.ref_point_pos <= 32'd1000;
      motor.motor_point_pos <= (i < 6) ? 32'(1000 + df[i]) : 32'd1000;
      motor.motor_rev <= 16'($urandom);
      motor.motor_angle <= 16'($urandom);
      if (i == 6) chk("A3 on", alarms.warn_a3, 32'h1);
      f0 = found_cnt;
      e0 = ev_cnt;
      @(posedge pclk);
      ref_return_start <= 1'b1;
      @(posedge pclk);
      ref_return_start <= 1'b0;
      for (int k = 0; k < (i < 6 ? ne[i] : 0); k++) scale.pulse(0);
      for (int k = 1; k < (i < 6 && sz[i] == 1 ? 3 : 4); k++) scale.pulse(1);
      chk("early found", 32'(found_cnt - f0), 32'h0);
      scale.pulse(1);
      cyc(4);
      chk("found", 32'(found_cnt - f0), 32'(fnd));
      chk("alarm42", alarms.alarm_42, 32'(bad));
      chk("event42", 32'(ev_cnt - e0), 32'(bad));
    end
    chk("A3 off", alarms.warn_a3, 32'h0);
    rdc("capture", `MERCC_OFF_CAPREV, {16'h0, motor.motor_rev});
    wr(`MERCC_OFF_CREV, rd);
    rdc("angle", `MERCC_OFF_CAPANG, {16'h0, motor.motor_angle});
    wr(`MERCC_OFF_CPHI, rd);
    apb(1'b0, `MERCC_OFF_CAPPOS, 32'h0);
    wr(`MERCC_OFF_CPLO, rd);
    $display("test reference done");
    scale.set(2, 1'b1);
    cyc(10);
    chk("battery low", alarms.alarm_9f, 32'h1);
    scale.set(2, 1'b0);
    cyc(10);
    chk("battery swap", alarms.alarm_9f, 32'h0);
    $display("test battery done");
    end_sim();
  end
endmodule : mercc_tb_top
bind mercc_top mercc_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pins(pins), .machine_step(machine_step), .scale_poles(scale_poles), .machine_step_out(machine_step_out),
  .ref_found(ref_found), .alarm_event(alarm_event), .alarms(alarms));
`default_nettype wire
